// >>> hw/capture_timer_defs.vh
`ifndef CAPTURE_TIMER_DEFS_VH
`define CAPTURE_TIMER_DEFS_VH

// ==========================================================
// Register indices (byte address is four times the index)
`define IDX_CONTROL_A     6'h00
`define IDX_CONTROL_B     6'h01
`define IDX_EVENT_CONTROL 6'h04
`define IDX_INT_ENABLE    6'h05
`define IDX_INT_FLAGS     6'h06
`define IDX_RUN_STATUS    6'h07
`define IDX_DEBUG_CONTROL 6'h08
`define IDX_TEMP_BYTE     6'h09
`define IDX_COUNTER_LOW   6'h0A
`define IDX_COUNTER_HIGH  6'h0B
`define IDX_COMPARE_LOW   6'h0C
`define IDX_COMPARE_HIGH  6'h0D

// ==========================================================
// Field positions
`define BIT_ENABLE        0
`define BIT_CAPTURE_INTERRUPT_BIT_EI       0
`define BIT_EDGE          4
`define BIT_INT           0
`define BIT_RUN           0
`define BIT_DEBUG_RUN     0
`define MODE_MSB          2
`define MODE_LSB          0

// ==========================================================
// Reset values
`define RESET_BYTE        8'h00
`define RESET_WORD        16'h0000
`define RESET_MODE        3'h0

// ==========================================================
// Count modes
`define MODE_PERIODIC     3'h0
`define MODE_TIMEOUT      3'h1
`define MODE_EVENT_CAPTURE_INTERRUPT_BIT   3'h2
`define MODE_FREQUENCY    3'h3
`define MODE_PULSE_WIDTH  3'h4
`define MODE_FREQ_PW      3'h5
`define MODE_SINGLE_SHOT  3'h6
`define MODE_PWM8         3'h7

`endif

// >>> hw/capture_timer_edge.v
`timescale 1ns/1ps
module capture_timer_edge (
	// Clock and reset
	input  wire clk,
	input  wire nrst,
	// Event level and edge pulses
	input  wire eventIn,
	output wire rise,
	output wire fall
);
	reg prev_q;

	always @(posedge clk) begin
		if (!nrst) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= eventIn;
		end
	end

	assign rise = eventIn & ~prev_q;
	assign fall = ~eventIn & prev_q;
endmodule

// >>> hw/capture_timer_apb.v
`timescale 1ns/1ps
`include "capture_timer_defs.vh"
module capture_timer_apb #(
	parameter ADDR_W = 8
) (
	// Clock and reset
	input  wire              clk,
	input  wire              nrst,
	// APB request
	input  wire              psel,
	input  wire              penable,
	input  wire              pwrite,
	input  wire [ADDR_W-1:0] paddr,
	// APB answer
	output wire              pready,
	output wire              pslverr,
	// Decoded strobes
	output wire              loadStb,
	output wire              writeStb,
	output wire [5:0]        regIdx
);
	reg  ready_q;
	reg  err_q;
	reg  mapped;
	wire [ADDR_W-1:0] wordAddr;

	assign wordAddr = paddr >> 2;
	assign regIdx   = wordAddr[5:0];

	always @* begin
		mapped = 1'b0;
		case (regIdx)
		`IDX_CONTROL_A, `IDX_CONTROL_B, `IDX_EVENT_CONTROL,
		`IDX_INT_ENABLE, `IDX_INT_FLAGS, `IDX_RUN_STATUS,
		`IDX_DEBUG_CONTROL, `IDX_TEMP_BYTE, `IDX_COUNTER_LOW,
		`IDX_COUNTER_HIGH, `IDX_COMPARE_LOW, `IDX_COMPARE_HIGH:
			mapped = 1'b1;
		default:
			mapped = 1'b0;
		endcase
		if (paddr[1:0] != 2'h0 || (wordAddr >> 6) != 0) begin
			mapped = 1'b0;
		end
	end

	// Access phase sample cycle and completion edge
	assign loadStb  = psel & penable & ~ready_q;
	assign writeStb = psel & penable & ready_q & pwrite & ~err_q;

	always @(posedge clk) begin
		if (!nrst) begin
			ready_q <= 1'b0;
			err_q   <= 1'b0;
		end else begin
			ready_q <= loadStb;
			err_q   <= loadStb & ~mapped;
		end
	end

	assign pready  = ready_q;
	assign pslverr = err_q;
endmodule

// >>> hw/capture_timer_register_file.v
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "capture_timer_defs.vh"
module capture_timer_register_file #(
	parameter ADDR_W = 8
) (
	// Clock and reset
	input  wire              clk,
	input  wire              nrst,
	// APB slave
	input  wire              psel,
	input  wire              penable,
	input  wire              pwrite,
	input  wire [ADDR_W-1:0] paddr,
	input  wire [31:0]       pwdata,
	output wire [31:0]       prdata,
	output wire              pready,
	output wire              pslverr,
	// Event input and debug halt
	input  wire              eventIn,
	input  wire              debugHalt,
	// Outputs
	output wire              irq,
	output wire              pwmOut
);
	// ======================================================
	// State
	reg        enable_q;
	reg        enable_d;
	reg [2:0]  mode_q;
	reg [2:0]  mode_d;
	reg        capture_event_input_enable_q;
	reg        capture_event_input_enable_d;
	reg        edge_q;
	reg        edge_d;
	reg        intEn_q;
	reg        intEn_d;
	reg        flag_q;
	reg        flag_d;
	reg        debugRun_q;
	reg        debugRun_d;
	reg [7:0]  temp_q;
	reg [7:0]  temp_d;
	reg [15:0] count_q;
	reg [15:0] count_d;
	reg [15:0] compare_q;
	reg [15:0] compare_d;
	reg        run_q;
	reg        run_d;
	reg [1:0]  phase_q;
	reg [1:0]  phase_d;
	reg        pwm_q;
	reg        pwm_d;
	reg        irq_q;
	reg [31:0] rdata_q;
	reg [7:0]  readData;
	reg        setFlag;
	reg        clrFlag;

	wire       loadStb;
	wire       writeStb;
	wire [5:0] regIdx;
	wire       rise;
	wire       fall;
	wire       active;
	wire       evOk;
	wire       selEdge;
	wire       oppEdge;
	wire       captMode;
	wire       pwmMode;
	wire [7:0] wd;
	wire [15:0] countInc;
	wire       aligned;

	// ======================================================
	// Bus slave and event edges
	capture_timer_apb #(
		.ADDR_W (ADDR_W)
	) u_apb (
		.clk      (clk),
		.nrst     (nrst),
		.psel     (psel),
		.penable  (penable),
		.pwrite   (pwrite),
		.paddr    (paddr),
		.pready   (pready),
		.pslverr  (pslverr),
		.loadStb  (loadStb),
		.writeStb (writeStb),
		.regIdx   (regIdx)
	);

	capture_timer_edge u_edge (
		.clk     (clk),
		.nrst    (nrst),
		.eventIn (eventIn),
		.rise    (rise),
		.fall    (fall)
	);

	assign wd       = pwdata[7:0];
	assign aligned  = (paddr[1:0] == 2'h0);
	assign countInc = count_q + 16'h0001;
	assign active   = enable_q & (~debugHalt | debugRun_q);
	assign evOk     = active & capture_event_input_enable_q;
	assign selEdge  = evOk & (edge_q ? fall : rise);
	assign oppEdge  = evOk & (edge_q ? rise : fall);
	assign pwmMode  = (mode_q == `MODE_PWM8);
	assign captMode = (mode_q == `MODE_EVENT_CAPTURE_INTERRUPT_BIT) ||
	                  (mode_q == `MODE_FREQUENCY) ||
	                  (mode_q == `MODE_PULSE_WIDTH) ||
	                  (mode_q == `MODE_FREQ_PW);

	// ======================================================
	// Read mux
	always @* begin
		readData = `RESET_BYTE;
		case (regIdx)
		`IDX_CONTROL_A:     readData = {7'h00, enable_q};
		`IDX_CONTROL_B:     readData = {5'h00, mode_q};
		`IDX_EVENT_CONTROL: readData = {3'h0, edge_q, 3'h0, capture_event_input_enable_q};
		`IDX_INT_ENABLE:    readData = {7'h00, intEn_q};
		`IDX_INT_FLAGS:     readData = {7'h00, flag_q};
		`IDX_RUN_STATUS:    readData = {7'h00, run_q};
		`IDX_DEBUG_CONTROL: readData = {7'h00, debugRun_q};
		`IDX_TEMP_BYTE:     readData = temp_q;
		`IDX_COUNTER_LOW:   readData = count_q[7:0];
		`IDX_COUNTER_HIGH:  readData = temp_q;
		`IDX_COMPARE_LOW:   readData = compare_q[7:0];
		`IDX_COMPARE_HIGH:  readData = pwmMode ? compare_q[15:8] : temp_q;
		default:            readData = `RESET_BYTE;
		endcase
	end

	// ======================================================
	// Counter and mode logic
	always @* begin
		count_d   = count_q;
		compare_d = compare_q;
		run_d     = run_q;
		phase_d   = phase_q;
		pwm_d     = pwm_q;
		setFlag   = 1'b0;
		if (!enable_q) begin
			run_d   = 1'b0;
			phase_d = 2'h0;
		end else if (active) begin
			case (mode_q)
			`MODE_PERIODIC: begin
				run_d = 1'b1;
				if (count_q == compare_q) begin
					count_d = `RESET_WORD;
					setFlag = 1'b1;
				end else begin
					count_d = countInc;
				end
			end
			`MODE_TIMEOUT: begin
				if (selEdge) begin
					run_d = 1'b1;
				end else if (oppEdge) begin
					run_d = 1'b0;
				end
				if (run_q) begin
					if (count_q == compare_q) begin
						count_d = `RESET_WORD;
						setFlag = 1'b1;
					end else begin
						count_d = countInc;
					end
				end
			end
			`MODE_EVENT_CAPTURE_INTERRUPT_BIT: begin
				run_d   = 1'b1;
				count_d = countInc;
				if (selEdge) begin
					compare_d = count_q;
					setFlag   = 1'b1;
				end
			end
			`MODE_FREQUENCY: begin
				run_d = 1'b1;
				if (selEdge) begin
					compare_d = count_q;
					count_d   = `RESET_WORD;
					setFlag   = 1'b1;
				end else begin
					count_d = countInc;
				end
			end
			`MODE_PULSE_WIDTH: begin
				run_d = 1'b1;
				if (selEdge) begin
					count_d = `RESET_WORD;
				end else begin
					count_d = countInc;
					if (oppEdge) begin
						compare_d = count_q;
						setFlag   = 1'b1;
					end
				end
			end
			`MODE_FREQ_PW: begin
				case (phase_q)
				2'h0: begin
					run_d = 1'b0;
					if (selEdge) begin
						count_d = `RESET_WORD;
						run_d   = 1'b1;
						phase_d = 2'h1;
					end
				end
				2'h1: begin
					count_d = countInc;
					if (oppEdge) begin
						compare_d = count_q;
						phase_d   = 2'h2;
					end
				end
				2'h2: begin
					count_d = countInc;
					if (selEdge) begin
						count_d = count_q;
						run_d   = 1'b0;
						setFlag = 1'b1;
						phase_d = 2'h0;
					end
				end
				default: begin
					phase_d = 2'h0;
				end
				endcase
			end
			`MODE_SINGLE_SHOT: begin
				if (!run_q) begin
					if (edge_q ? (rise | fall) & evOk : selEdge) begin
						run_d   = 1'b1;
						count_d = `RESET_WORD;
					end
				end else if (count_q == compare_q) begin
					run_d   = 1'b0;
					count_d = `RESET_WORD;
					setFlag = 1'b1;
				end else begin
					count_d = countInc;
				end
			end
			`MODE_PWM8: begin
				run_d = 1'b1;
				if (count_q[7:0] == compare_q[15:8]) begin
					setFlag = 1'b1;
				end
				if (count_q[7:0] == compare_q[7:0]) begin
					count_d = `RESET_WORD;
					pwm_d   = 1'b1;
				end else begin
					count_d = {8'h00, countInc[7:0]};
				end
				// Low from the count reaching the high compare byte until the next top match
				if (count_d[7:0] == compare_q[15:8]) begin
					pwm_d = 1'b0;
				end
			end
			default: begin
				run_d = 1'b0;
			end
			endcase
		end
	end

	// ======================================================
	// Software writes and read side effects
	always @* begin
		enable_d   = enable_q;
		mode_d     = mode_q;
		capture_event_input_enable_d   = capture_event_input_enable_q;
		edge_d     = edge_q;
		intEn_d    = intEn_q;
		debugRun_d = debugRun_q;
		temp_d     = temp_q;
		clrFlag    = 1'b0;
		if (loadStb && !pwrite && aligned) begin
			if (regIdx == `IDX_COUNTER_LOW) begin
				temp_d = count_q[15:8];
			end
			if (regIdx == `IDX_COMPARE_LOW) begin
				if (!pwmMode) begin
					temp_d = compare_q[15:8];
				end
				if (captMode) begin
					clrFlag = 1'b1;
				end
			end
		end
		if (writeStb) begin
			case (regIdx)
			`IDX_CONTROL_A:     enable_d   = wd[`BIT_ENABLE];
			`IDX_CONTROL_B:     mode_d     = wd[`MODE_MSB:`MODE_LSB];
			`IDX_EVENT_CONTROL: begin
				capture_event_input_enable_d = wd[`BIT_CAPTURE_INTERRUPT_BIT_EI];
				edge_d   = wd[`BIT_EDGE];
			end
			`IDX_INT_ENABLE:    intEn_d    = wd[`BIT_INT];
			`IDX_INT_FLAGS:     clrFlag    = wd[`BIT_INT];
			`IDX_DEBUG_CONTROL: debugRun_d = wd[`BIT_DEBUG_RUN];
			`IDX_TEMP_BYTE:     temp_d     = wd;
			`IDX_COUNTER_LOW:   temp_d     = wd;
			`IDX_COMPARE_LOW: begin
				if (!pwmMode) begin
					temp_d = wd;
				end
			end
			default: begin
				temp_d = temp_q;
			end
			endcase
		end
		flag_d = setFlag | (flag_q & ~clrFlag);
	end

	// ======================================================
	// Registers
	always @(posedge clk) begin
		if (!nrst) begin
			enable_q   <= 1'b0;
			mode_q     <= `RESET_MODE;
			capture_event_input_enable_q   <= 1'b0;
			edge_q     <= 1'b0;
			intEn_q    <= 1'b0;
			flag_q     <= 1'b0;
			debugRun_q <= 1'b0;
			temp_q     <= `RESET_BYTE;
			count_q    <= `RESET_WORD;
			compare_q  <= `RESET_WORD;
			run_q      <= 1'b0;
			phase_q    <= 2'h0;
			pwm_q      <= 1'b0;
			irq_q      <= 1'b0;
			rdata_q    <= 32'h00000000;
		end else begin
			enable_q   <= enable_d;
			mode_q     <= mode_d;
			capture_event_input_enable_q   <= capture_event_input_enable_d;
			edge_q     <= edge_d;
			intEn_q    <= intEn_d;
			flag_q     <= flag_d;
			debugRun_q <= debugRun_d;
			temp_q     <= temp_d;
			run_q      <= run_d;
			pwm_q      <= pwmMode & enable_q ? pwm_d : 1'b0;
			irq_q      <= intEn_d & flag_d;
			phase_q    <= (writeStb && regIdx == `IDX_CONTROL_B) ?
			              2'h0 : phase_d;
			if (loadStb) begin
				rdata_q <= aligned ? {24'h000000, readData} :
				           32'h00000000;
			end
			count_q <= count_d;
			if (writeStb && regIdx == `IDX_COUNTER_HIGH) begin
				count_q <= {wd, temp_q};
			end
			compare_q <= compare_d;
			if (writeStb && regIdx == `IDX_COMPARE_LOW && pwmMode) begin
				compare_q <= {compare_d[15:8], wd};
			end
			if (writeStb && regIdx == `IDX_COMPARE_HIGH) begin
				if (pwmMode) begin
					compare_q <= {wd, compare_d[7:0]};
				end else begin
					compare_q <= {wd, temp_q};
				end
			end
		end
	end

	assign prdata = rdata_q;
	assign irq    = irq_q;
	assign pwmOut = pwm_q;
endmodule

// >>> bench/capture_timer_register_file_chk.sv
`timescale 1ns/1ps
module capture_timer_register_file_chk #(
	parameter ADDR_W = 8
) (
	// Clock and reset
	input wire logic              clk,
	input wire logic              nrst,
	// APB slave
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	// Event input and debug halt
	input wire logic              eventIn,
	input wire logic              debugHalt,
	// Outputs
	input wire logic              irq,
	input wire logic              pwmOut
);
	// ==========================================================
	// Decode helpers
	logic       acc;
	logic       mapped;
	logic [5:0] idx;
	assign idx    = paddr[7:2];
	assign acc    = psel && penable && pready;
	assign mapped = idx <= 6'h0D && idx != 6'h02 && idx != 6'h03;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// ==========================================================
	// Bus and flag properties
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	chk_one_wait: assert property (psel && penable && !$past(penable)
		|-> !pready ##1 pready) else $error("wait state count wrong");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	chk_ready_access: assert property (pready
		|-> psel && penable && $past(psel && penable))
		else $error("ready outside access");
	chk_unaligned_err: assert property (acc && paddr[1:0] != 2'h0
		|-> pslverr) else $error("unaligned not refused");
	chk_unmapped_err: assert property (acc && !mapped |-> pslverr)
		else $error("unmapped not refused");
	chk_mapped_ok: assert property (acc && mapped && paddr[1:0] == 2'h0
		|-> !pslverr) else $error("mapped access refused");
	chk_refused_data: assert property (acc && !pwrite && pslverr
		|-> prdata == 32'h0) else $error("refused read data not zero");
	chk_run_readonly: assert property (acc && !pwrite && idx == 6'h07
		|-> prdata[31:1] == 31'h0) else $error("status spare bits set");
	chk_irq_clear: assert property ($fell(irq) |-> $past(psel))
		else $error("irq fell without bus access");
endmodule

bind capture_timer_register_file capture_timer_register_file_chk #(
	.ADDR_W(ADDR_W)
) i_chk (
	.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .eventIn(eventIn),
	.debugHalt(debugHalt), .irq(irq), .pwmOut(pwmOut)
);

// >>> bench/capture_timer_register_file_tb.sv
`timescale 1ns/1ps
`include "capture_timer_defs.vh"
module capture_timer_register_file_tb;
	// ==========================================================
	// Signals
	logic        clk, nrst, psel, penable, pwrite, eventIn, debugHalt;
	logic        lastIrq, pwmOn, e;
	logic [7:0]  paddr, r, h;
	logic [31:0] pwdata;
	logic [15:0] w, a, b;
	wire  [31:0] prdata;
	wire         pready, pslverr, irq, pwmOut;
	int          numErrors, numChecks, cyc, k, t0, ones;
	int          riseQ[$];

	capture_timer_register_file i_capture_timer_register_file (
		.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .eventIn(eventIn),
		.debugHalt(debugHalt), .irq(irq), .pwmOut(pwmOut)
	);

	// ==========================================================
	// Clock, model of interrupt timing and output duty
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		lastIrq <= irq;
		if (irq === 1'h1 && lastIrq === 1'h0) riseQ.push_back(cyc);
		if (pwmOn) ones <= ones + int'(pwmOut);
	end

	// ==========================================================
	// Tasks
	task chk(input string nm, input logic [15:0] x, input logic [15:0] g);
		numChecks++;
		if (g !== x) begin
			numErrors++;
			$display("MISMATCH %s expected %0h seen %0h", nm, x, g);
		end
	endtask
	task bus(input logic wr, input logic [7:0] ad, input logic [7:0] d);
		int n;
		@(posedge clk);
		psel    <= 1'h1;
		pwrite  <= wr;
		paddr   <= ad;
		pwdata  <= {24'h0, d};
		@(posedge clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (n == 50) numErrors++;
		r = prdata[7:0];
		e = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask
	task wr(input logic [5:0] i, input logic [7:0] d);
		bus(1'h1, {i, 2'h0}, d);
	endtask
	task rdc(input logic [5:0] i, input logic [7:0] x);
		bus(1'h0, {i, 2'h0}, 8'h00);
		chk($sformatf("reg %0h", i), 16'(x), 16'(r));
	endtask
	task wr16(input logic [5:0] i, input logic [15:0] d);
		wr(i, d[7:0]);
		wr(i + 6'h01, d[15:8]);
	endtask
	task rd16(input logic [5:0] i, output logic [15:0] o);
		bus(1'h0, {i, 2'h0}, 8'h00);
		o[7:0] = r;
		bus(1'h0, {i + 6'h01, 2'h0}, 8'h00);
		o[15:8] = r;
	endtask
	task pair(input int d, output logic [15:0] x, output logic [15:0] y);
		@(posedge clk);
		eventIn <= 1'h1;
		t0 = cyc;
		repeat (3) @(posedge clk);
		chk("irq", 16'h1, 16'(irq));
		rdc(`IDX_INT_FLAGS, 8'h01);
		rd16(`IDX_COMPARE_LOW, x);
		chk("irq clr", 16'h0, 16'(irq));
		eventIn <= 1'h0;
		while (cyc < t0 + d) @(posedge clk);
		eventIn <= 1'h1;
		repeat (3) @(posedge clk);
		rd16(`IDX_COMPARE_LOW, y);
		eventIn <= 1'h0;
	endtask
	task finish_test;
		$display("checks %0d errors %0d", numChecks, numErrors);
		if (numErrors == 0 && numChecks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ==========================================================
	// Watchdog
	initial begin
		#100000;
		numErrors++;
		finish_test;
	end

	// ==========================================================
	// Main sequence
	initial begin
		{psel, penable, pwrite, eventIn, debugHalt, pwmOn} = 6'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		nrst = 1'h0;
		{numErrors, numChecks, cyc, ones} = 0;
		void'($urandom(32'h813AB42C));
		repeat (16) @(posedge clk);
		nrst <= 1'h1;
		// Reset values and address decode
		for (k = 0; k < 16; k++) begin
			bus(1'h0, 8'(k * 4), 8'h00);
			chk("reset", 16'h0, 16'(r));
			chk("decode", 16'(k inside {2, 3, 14, 15}), 16'(e));
		end
		bus(1'h0, 8'h29, 8'h00);
		chk("unaligned", 16'h1, 16'(e));
		// Register access
		h = 8'($urandom);
		wr(`IDX_TEMP_BYTE, h);
		rdc(`IDX_TEMP_BYTE, h);
		wr(`IDX_RUN_STATUS, 8'hFF);
		rdc(`IDX_RUN_STATUS, 8'h00);
		w = 16'($urandom);
		wr16(`IDX_COUNTER_LOW, w);
		rd16(`IDX_COUNTER_LOW, a);
		chk("counter", w, a);
		rdc(`IDX_TEMP_BYTE, w[15:8]);
		for (k = 0; k < 8; k++) begin
			wr(`IDX_CONTROL_B, 8'(k));
			rdc(`IDX_CONTROL_B, 8'(k));
		end
		// Captures
		wr(`IDX_CONTROL_B, {5'h0, `MODE_EVENT_CAPTURE_INTERRUPT_BIT});
		wr(`IDX_INT_ENABLE, 8'h01);
		wr(`IDX_CONTROL_A, 8'h01);
		@(posedge clk) eventIn <= 1'h1;
		repeat (4) @(posedge clk) eventIn <= 1'h0;
		chk("no capture", 16'h0, 16'(irq));
		wr(`IDX_EVENT_CONTROL, 8'h01);
		pair(60, a, b);
		chk("capture gap", 16'd60, b - a);
		wr(`IDX_CONTROL_B, {5'h0, `MODE_FREQUENCY});
		pair(45, a, b);
		chk("frequency", 16'd44, b);
		// Pulse width and combined measurement
		wr(`IDX_CONTROL_B, {5'h0, `MODE_PULSE_WIDTH});
		k = $urandom_range(20, 60);
		@(posedge clk) eventIn <= 1'h1;
		repeat (k) @(posedge clk);
		eventIn <= 1'h0;
		repeat (3) @(posedge clk);
		chk("pw irq", 16'h1, 16'(irq));
		rd16(`IDX_COMPARE_LOW, a);
		chk("pulse width", 16'(k - 1), a);
		wr(`IDX_CONTROL_B, {5'h0, `MODE_FREQ_PW});
		@(posedge clk) eventIn <= 1'h1;
		repeat (k) @(posedge clk);
		eventIn <= 1'h0;
		repeat (20) @(posedge clk);
		eventIn <= 1'h1;
		repeat (3) @(posedge clk);
		chk("combined irq", 16'h1, 16'(irq));
		rdc(`IDX_RUN_STATUS, 8'h00);
		rd16(`IDX_COUNTER_LOW, b);
		chk("combined stop", 16'(k + 19), b);
		rd16(`IDX_COMPARE_LOW, a);
		chk("combined capture", 16'(k - 1), a);
		eventIn <= 1'h0;
		// Periodic top match
		wr(`IDX_CONTROL_A, 8'h00);
		wr16(`IDX_COMPARE_LOW, 16'd100);
		wr16(`IDX_COUNTER_LOW, 16'h0);
		wr(`IDX_CONTROL_B, {5'h0, `MODE_PERIODIC});
		wr(`IDX_INT_FLAGS, 8'h01);
		riseQ.delete();
		wr(`IDX_CONTROL_A, 8'h01);
		rdc(`IDX_RUN_STATUS, 8'h01);
		for (k = 0; k < 200 && irq !== 1'h1; k++) @(posedge clk);
		wr(`IDX_INT_FLAGS, 8'h00);
		rdc(`IDX_INT_FLAGS, 8'h01);
		wr(`IDX_INT_FLAGS, 8'h01);
		for (k = 0; k < 400 && riseQ.size() < 2; k++) @(posedge clk);
		chk("period", 16'd101, 16'(riseQ[1] - riseQ[0]));
		// Debug halt
		@(posedge clk) debugHalt <= 1'h1;
		rd16(`IDX_COUNTER_LOW, a);
		repeat (20) @(posedge clk);
		rd16(`IDX_COUNTER_LOW, b);
		chk("halted", a, b);
		wr(`IDX_DEBUG_CONTROL, 8'h01);
		rd16(`IDX_COUNTER_LOW, a);
		repeat (20) @(posedge clk);
		rd16(`IDX_COUNTER_LOW, b);
		chk("debug run", 16'h1, 16'(a !== b));
		debugHalt <= 1'h0;
		// Single shot
		wr(`IDX_CONTROL_A, 8'h00);
		wr(`IDX_CONTROL_B, {5'h0, `MODE_SINGLE_SHOT});
		wr(`IDX_INT_FLAGS, 8'h01);
		wr(`IDX_CONTROL_A, 8'h01);
		rdc(`IDX_RUN_STATUS, 8'h00);
		@(posedge clk) eventIn <= 1'h1;
		repeat (90) @(posedge clk);
		chk("shot early", 16'h0, 16'(irq));
		repeat (20) @(posedge clk);
		chk("shot flag", 16'h1, 16'(irq));
		rdc(`IDX_RUN_STATUS, 8'h00);
		eventIn <= 1'h0;
		// Eight-bit PWM
		wr(`IDX_CONTROL_A, 8'h00);
		wr(`IDX_CONTROL_B, {5'h0, `MODE_PWM8});
		wr16(`IDX_COUNTER_LOW, 16'h0);
		h = 8'($urandom_range(1, 8));
		wr(`IDX_COMPARE_LOW, 8'h09);
		wr(`IDX_COMPARE_HIGH, h);
		rdc(`IDX_COMPARE_HIGH, h);
		rdc(`IDX_COMPARE_LOW, 8'h09);
		wr(`IDX_INT_FLAGS, 8'h01);
		wr(`IDX_CONTROL_A, 8'h01);
		repeat (30) @(posedge clk);
		pwmOn <= 1'h1;
		repeat (50) @(posedge clk);
		pwmOn <= 1'h0;
		@(posedge clk);
		chk("pwm duty", 16'(5 * h), 16'(ones));
		chk("pwm flag", 16'h1, 16'(irq));
		finish_test;
	end
endmodule
